// ---- src/tx_clock_sync_pins.sv ----
// Behaviour
// - Interleaved bus carries several framers per stream.
// - Control selects recovered receive clock as source.
// - Backplane clock used only with elastic store.
// - Compat mode makes clock one the master.
// - Status pins show selected loss or freeze.
// - Status pins enabled only in compat mode.
// - Sync input pulse sets transmit boundary.
// - Sync output pulses each frame or multiframe.
// - Optional double-wide pulse at T1 signaling frames, without elastic store only.
// - Line-mode sync pin follows line clock.
// - Elastic store switches pin to system sync.
// - System sync follows backplane clock, or recovered clock without elastic store.
// - Elastic output gives 8 kHz backplane pulse, or multiframe pulse with SYNC_MF.
`timescale 1ns/10ps
`default_nettype none
module tx_clock_sync_pins (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic TX_LINE_CLK,
   input wire logic RX_REC_CLK,
   input wire logic BP_CLK_OWN,
   input wire logic BP_CLK_ONE,
   input wire logic TX_SYNC_I,
   input wire logic ELASTIC_EN,
   input wire logic COMPAT_MODE,
   input wire logic TX_CLK_FROM_RX,
   input wire logic IBO_EN,
   input wire logic [2:0] BP_RATE,
   input wire logic T1_MODE,
   input wire logic SYNC_IS_OUT,
   input wire logic SYNC_MF,
   input wire logic SYNC_DBL_WIDE,
   input wire logic [1:0] STATUS_SEL,
   input wire logic [6:0] ANALOG_LOSS,
   input wire logic [6:0] FRAMER_LOSS,
   input wire logic [6:0] RX_SIG_FREEZE,
   output logic TX_SYNC_O,
   output logic TX_SYNC_OE_B,
   output logic [6:0] STATUS_O,
   output logic [6:0] STATUS_OE_B,
   output logic [2:0] IBO_SLOT
);

   // Line clock domain state
   typedef struct packed {
      logic rst_m;
      logic rst_s;
      logic act_m;
      logic act_s;
      logic mf_m;
      logic mf_s;
      logic t1_m;
      logic t1_s;
      logic dbl_m;
      logic dbl_s;
      logic out_m;
      logic out_s;
      logic sy_m;
      logic sy_s;
      logic sy_p;
      logic lp_d1;
      logic lp_str;
   } lnk_st_t;

   // Reference clock domain state
   typedef struct packed {
      logic rck_m;
      logic rck_s;
      logic rck_p;
      logic bpo_m;
      logic bpo_s;
      logic bpo_p;
      logic bp1_m;
      logic bp1_s;
      logic bp1_p;
      logic sy_m;
      logic sy_s;
      logic sy_p;
      logic sync_pend;
      logic lp_m;
      logic lp_s;
      logic sync_o;
      logic sync_oe_b;
      logic [6:0] st_o;
      logic [6:0] st_oe_b;
      logic [2:0] ibo_slot;
   } ref_st_t;

   lnk_st_t lnk_q;
   lnk_st_t lnk_d;
   ref_st_t ref_q;
   ref_st_t ref_d;

   frame_tmr_if line_tmr ();
   frame_tmr_if sys_tmr ();

   logic line_mode;
   logic sys_edge;
   logic sys_step;
   logic sy_edge;
   logic [10:0] sys_last;
   logic [2:0] slot_mask;

   // ---------------- Line clock domain ----------------
   // Line-timed sync pulse is generated here so it stays on the line clock
   always_comb
   begin
      lnk_d = lnk_q;
      lnk_d.rst_m = RST_B;
      lnk_d.rst_s = lnk_q.rst_m;
      lnk_d.act_m = ~ELASTIC_EN & ~TX_CLK_FROM_RX;
      lnk_d.act_s = lnk_q.act_m;
      lnk_d.mf_m = SYNC_MF;
      lnk_d.mf_s = lnk_q.mf_m;
      lnk_d.t1_m = T1_MODE;
      lnk_d.t1_s = lnk_q.t1_m;
      lnk_d.dbl_m = SYNC_DBL_WIDE;
      lnk_d.dbl_s = lnk_q.dbl_m;
      lnk_d.out_m = SYNC_IS_OUT;
      lnk_d.out_s = lnk_q.out_m;
      lnk_d.sy_m = TX_SYNC_I;
      lnk_d.sy_s = lnk_q.sy_m;
      lnk_d.sy_p = lnk_q.sy_s;
      // Stretched by one line bit so a pulse outlives a reference period
      // even at fast line clocks; the pin pulse is one bit wider for it
      lnk_d.lp_d1 = line_tmr.pulse;
      lnk_d.lp_str = line_tmr.pulse | lnk_q.lp_d1;
      if (!lnk_q.rst_s)
      begin
         lnk_d.act_s = 1'b0;
         lnk_d.sy_p = 1'b0;
         lnk_d.lp_d1 = 1'b0;
         lnk_d.lp_str = 1'b0;
      end
   end

   always_ff @(posedge TX_LINE_CLK)
   begin
      lnk_q <= lnk_d;
   end

   assign line_tmr.step = lnk_q.act_s;
   assign line_tmr.realign = lnk_q.sy_s & ~lnk_q.sy_p & ~lnk_q.out_s;
   assign line_tmr.mf_sel = lnk_q.mf_s;
   assign line_tmr.t1_sel = lnk_q.t1_s;
   assign line_tmr.dbl_sel = lnk_q.dbl_s;
   assign line_tmr.frame_last = lnk_q.t1_s ? tx_sync_pkg::LAST_BIT_1M544 : tx_sync_pkg::LAST_BIT_2M048;

   frame_timer u_line_timer (
      .clk(TX_LINE_CLK),
      .rst_b(lnk_q.rst_s),
      .tmr(line_tmr.timer)
   );

   // ---------------- Reference clock domain ----------------
   // Port one's backplane clock governs in compat mode with the elastic store, the recovered
   // clock governs when the transmit clock is taken from receive without the elastic store
   assign line_mode = ~ELASTIC_EN & ~TX_CLK_FROM_RX;
   assign sys_edge = ELASTIC_EN ?
                     (COMPAT_MODE ? (ref_q.bp1_s & ~ref_q.bp1_p) : (ref_q.bpo_s & ~ref_q.bpo_p)) :
                     (ref_q.rck_s & ~ref_q.rck_p);
   assign sys_step = sys_edge & ~line_mode;
   assign sy_edge = ref_q.sy_s & ~ref_q.sy_p & ~SYNC_IS_OUT & ~line_mode;

   always_comb
   begin
      sys_last = tx_sync_pkg::LAST_BIT_2M048;
      slot_mask = 3'h0;
      if (ELASTIC_EN)
      begin
         case (BP_RATE)
            tx_sync_pkg::RATE_1M544: sys_last = tx_sync_pkg::LAST_BIT_1M544;
            tx_sync_pkg::RATE_2M048: sys_last = tx_sync_pkg::LAST_BIT_2M048;
            tx_sync_pkg::RATE_4M096:
            begin
               sys_last = tx_sync_pkg::LAST_BIT_4M096;
               slot_mask = tx_sync_pkg::SLOT_MASK_4M096;
            end
            tx_sync_pkg::RATE_8M192:
            begin
               sys_last = tx_sync_pkg::LAST_BIT_8M192;
               slot_mask = tx_sync_pkg::SLOT_MASK_8M192;
            end
            tx_sync_pkg::RATE_16M384:
            begin
               sys_last = tx_sync_pkg::LAST_BIT_16M384;
               slot_mask = tx_sync_pkg::SLOT_MASK_16M384;
            end
            default: sys_last = tx_sync_pkg::LAST_BIT_2M048;
         endcase
      end
      else if (T1_MODE)
      begin
         sys_last = tx_sync_pkg::LAST_BIT_1M544;
      end
   end

   assign sys_tmr.step = sys_step;
   assign sys_tmr.realign = ref_q.sync_pend | sy_edge;
   assign sys_tmr.mf_sel = SYNC_MF;
   assign sys_tmr.t1_sel = T1_MODE;
   assign sys_tmr.dbl_sel = SYNC_DBL_WIDE & ~ELASTIC_EN;
   assign sys_tmr.frame_last = sys_last;

   frame_timer u_sys_timer (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .tmr(sys_tmr.timer)
   );

   always_comb
   begin
      ref_d = ref_q;
      ref_d.rck_m = RX_REC_CLK;
      ref_d.rck_s = ref_q.rck_m;
      ref_d.rck_p = ref_q.rck_s;
      ref_d.bpo_m = BP_CLK_OWN;
      ref_d.bpo_s = ref_q.bpo_m;
      ref_d.bpo_p = ref_q.bpo_s;
      ref_d.bp1_m = BP_CLK_ONE;
      ref_d.bp1_s = ref_q.bp1_m;
      ref_d.bp1_p = ref_q.bp1_s;
      ref_d.sy_m = TX_SYNC_I;
      ref_d.sy_s = ref_q.sy_m;
      ref_d.sy_p = ref_q.sy_s;
      // A sync seen between clock edges waits for the next governing edge
      ref_d.sync_pend = (ref_q.sync_pend | sy_edge) & ~sys_step;
      ref_d.lp_m = lnk_q.lp_str;
      ref_d.lp_s = ref_q.lp_m;

      ref_d.sync_oe_b = ~SYNC_IS_OUT;
      if (!SYNC_IS_OUT)
      begin
         ref_d.sync_o = 1'b0;
      end
      else if (line_mode)
      begin
         // Stretched pulse outlasts a reference period, so a level crossing cannot miss it
         ref_d.sync_o = ref_q.lp_s;
      end
      else
      begin
         ref_d.sync_o = sys_tmr.pulse;
      end

      ref_d.st_oe_b = COMPAT_MODE ? 7'h00 : 7'h7F;
      case (STATUS_SEL)
         tx_sync_pkg::STAT_ANALOG_LOSS: ref_d.st_o = ANALOG_LOSS;
         tx_sync_pkg::STAT_FRAMER_LOSS: ref_d.st_o = FRAMER_LOSS;
         tx_sync_pkg::STAT_SIG_FREEZE: ref_d.st_o = RX_SIG_FREEZE;
         default: ref_d.st_o = 7'h00;
      endcase
      if (!COMPAT_MODE)
      begin
         ref_d.st_o = 7'h00;
      end

      // Byte-interleaved slot of the framer whose data is on the stream
      if (IBO_EN && ELASTIC_EN)
      begin
         ref_d.ibo_slot = sys_tmr.bit_cnt[tx_sync_pkg::SLOT_LSB +: 3] & slot_mask;
      end
      else
      begin
         ref_d.ibo_slot = 3'h0;
      end

      if (!RST_B)
      begin
         ref_d.rck_p = 1'b0;
         ref_d.bpo_p = 1'b0;
         ref_d.bp1_p = 1'b0;
         ref_d.sy_p = 1'b0;
         ref_d.sync_pend = 1'b0;
         ref_d.sync_o = 1'b0;
         ref_d.sync_oe_b = 1'b1;
         ref_d.st_o = 7'h00;
         ref_d.st_oe_b = 7'h7F;
         ref_d.ibo_slot = 3'h0;
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      ref_q <= ref_d;
   end

   assign TX_SYNC_O = ref_q.sync_o;
   assign TX_SYNC_OE_B = ref_q.sync_oe_b;
   assign STATUS_O = ref_q.st_o;
   assign STATUS_OE_B = ref_q.st_oe_b;
   assign IBO_SLOT = ref_q.ibo_slot;

endmodule
`default_nettype wire

// ---- src/tx_sync_pkg.sv ----
package tx_sync_pkg;

   // Backplane clock rate codes
   localparam logic [2:0] RATE_1M544 = 3'h0;
   localparam logic [2:0] RATE_2M048 = 3'h1;
   localparam logic [2:0] RATE_4M096 = 3'h2;
   localparam logic [2:0] RATE_8M192 = 3'h3;
   localparam logic [2:0] RATE_16M384 = 3'h4;

   // Last bit index of one 125 us frame at each rate
   localparam logic [10:0] LAST_BIT_1M544 = 11'h0C0;
   localparam logic [10:0] LAST_BIT_2M048 = 11'h0FF;
   localparam logic [10:0] LAST_BIT_4M096 = 11'h1FF;
   localparam logic [10:0] LAST_BIT_8M192 = 11'h3FF;
   localparam logic [10:0] LAST_BIT_16M384 = 11'h7FF;

   // Multiframe length and T1 signaling frame spacing
   localparam logic [4:0] LAST_FRM_T1 = 5'h17;
   localparam logic [4:0] LAST_FRM_E1 = 5'h0F;
   localparam logic [4:0] SIG_FRM_SPACING = 5'h06;
   localparam logic [10:0] DBL_WIDE_BIT = 11'h001;

   // Interleaved bus slot masks (framers per stream minus one)
   localparam logic [2:0] SLOT_MASK_4M096 = 3'h1;
   localparam logic [2:0] SLOT_MASK_8M192 = 3'h3;
   localparam logic [2:0] SLOT_MASK_16M384 = 3'h7;
   localparam int SLOT_LSB = 3;

   // Status pin source select
   localparam logic [1:0] STAT_ANALOG_LOSS = 2'h0;
   localparam logic [1:0] STAT_FRAMER_LOSS = 2'h1;
   localparam logic [1:0] STAT_SIG_FREEZE = 2'h2;

   localparam int STATUS_PINS = 7;

endpackage

// ---- src/frame_tmr_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface frame_tmr_if;
   logic step;
   logic realign;
   logic mf_sel;
   logic t1_sel;
   logic dbl_sel;
   logic [10:0] frame_last;
   logic pulse;
   logic [10:0] bit_cnt;

   modport owner (output step, output realign, output mf_sel, output t1_sel,
                  output dbl_sel, output frame_last, input pulse, input bit_cnt);
   modport timer (input step, input realign, input mf_sel, input t1_sel,
                  input dbl_sel, input frame_last, output pulse, output bit_cnt);
endinterface
`default_nettype wire

// ---- src/frame_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module frame_timer (
   input wire logic clk,
   input wire logic rst_b,
   frame_tmr_if.timer tmr
);
   typedef struct packed {
      logic [10:0] bit_cnt;
      logic [4:0] frm_cnt;
      logic pulse;
   } tmr_st_t;

   tmr_st_t st_q;
   tmr_st_t st_d;
   logic [4:0] last_frm;
   logic sig_frm;

   always_comb
   begin
      st_d = st_q;
      last_frm = tmr.t1_sel ? tx_sync_pkg::LAST_FRM_T1 : tx_sync_pkg::LAST_FRM_E1;
      sig_frm = 1'b0;
      if (tmr.step)
      begin
         if (tmr.realign)
         begin
            st_d.bit_cnt = '0;
            if (tmr.mf_sel)
            begin
               st_d.frm_cnt = '0;
            end
         end
         else if (st_q.bit_cnt == tmr.frame_last)
         begin
            st_d.bit_cnt = '0;
            st_d.frm_cnt = (st_q.frm_cnt == last_frm) ? 5'h00 : st_q.frm_cnt + 5'h01;
         end
         else
         begin
            st_d.bit_cnt = st_q.bit_cnt + 11'h001;
         end
         sig_frm = (st_d.frm_cnt % tx_sync_pkg::SIG_FRM_SPACING) == (tx_sync_pkg::SIG_FRM_SPACING - 5'h01);
         if (tmr.mf_sel)
         begin
            st_d.pulse = (st_d.bit_cnt == '0) && (st_d.frm_cnt == '0);
         end
         else
         begin
            st_d.pulse = (st_d.bit_cnt == '0) ||
                         (tmr.dbl_sel && tmr.t1_sel && sig_frm && st_d.bit_cnt == tx_sync_pkg::DBL_WIDE_BIT);
         end
      end
      if (!rst_b)
      begin
         st_d = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      st_q <= st_d;
   end

   assign tmr.pulse = st_q.pulse;
   assign tmr.bit_cnt = st_q.bit_cnt;
endmodule
`default_nettype wire

// ---- verif/bp_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
module bp_partner (
   input wire logic line_clk,
   input wire logic en,
   input wire logic sync_en,
   input wire logic [10:0] last_bit,
   output logic bp_clk,
   output logic sync
);
   logic [1:0] div_q = 2'h0;
   logic [10:0] bit_q = 11'h000;
   // Divided from the line clock so the store can never slip
   always @(posedge line_clk)
   begin
      div_q <= div_q + 2'h1;
   end
   assign bp_clk = en & div_q[1];
   always @(posedge bp_clk)
   begin
      bit_q <= (bit_q >= last_bit) ? 11'h000 : bit_q + 11'h001;
   end
   // Pin is tied low whenever the partner is not the source
   assign sync = en & sync_en & (bit_q == 11'h000);
endmodule
`default_nettype wire

// ---- verif/tx_clock_sync_pins_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module tx_clock_sync_pins_checker (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic ELASTIC_EN,
   input wire logic COMPAT_MODE,
   input wire logic IBO_EN,
   input wire logic [2:0] BP_RATE,
   input wire logic SYNC_IS_OUT,
   input wire logic [1:0] STATUS_SEL,
   input wire logic [6:0] ANALOG_LOSS,
   input wire logic [6:0] FRAMER_LOSS,
   input wire logic [6:0] RX_SIG_FREEZE,
   input wire logic TX_SYNC_OE_B,
   input wire logic [6:0] STATUS_O,
   input wire logic [6:0] STATUS_OE_B,
   input wire logic [2:0] IBO_SLOT
);
   default clocking dc @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);
   a_status_off: assert property (!COMPAT_MODE |=> STATUS_O == 7'h00 && STATUS_OE_B == 7'h7F)
      else $error("status pins active outside compat mode");
   a_status_on: assert property (COMPAT_MODE |=> STATUS_OE_B == 7'h00)
      else $error("status pins not driven in compat mode");
   a_status_analog: assert property (COMPAT_MODE && STATUS_SEL == tx_sync_pkg::STAT_ANALOG_LOSS
      |=> STATUS_O == $past(ANALOG_LOSS))
      else $error("analog loss not shown");
   a_status_framer: assert property (COMPAT_MODE && STATUS_SEL == tx_sync_pkg::STAT_FRAMER_LOSS
      |=> STATUS_O == $past(FRAMER_LOSS))
      else $error("framer loss not shown");
   a_status_freeze: assert property (COMPAT_MODE && STATUS_SEL == tx_sync_pkg::STAT_SIG_FREEZE
      |=> STATUS_O == $past(RX_SIG_FREEZE))
      else $error("signaling freeze not shown");
   a_pin_output: assert property (SYNC_IS_OUT |=> !TX_SYNC_OE_B)
      else $error("sync pin not driven");
   a_pin_input: assert property (!SYNC_IS_OUT |=> TX_SYNC_OE_B)
      else $error("sync pin driven in input mode");
   a_slot_idle: assert property ((!IBO_EN)[*2] |=> IBO_SLOT == 3'h0)
      else $error("slot moves without interleaved bus");
   a_slot_masked: assert property ((ELASTIC_EN && IBO_EN && BP_RATE == tx_sync_pkg::RATE_4M096)[*2]
      |=> IBO_SLOT[2:1] == 2'h0)
      else $error("slot beyond two framers");
endmodule
bind tx_clock_sync_pins tx_clock_sync_pins_checker i_chk (.REF_CLK, .RST_B, .ELASTIC_EN, .COMPAT_MODE, .IBO_EN,
   .BP_RATE, .SYNC_IS_OUT, .STATUS_SEL, .ANALOG_LOSS, .FRAMER_LOSS, .RX_SIG_FREEZE, .TX_SYNC_OE_B, .STATUS_O,
   .STATUS_OE_B, .IBO_SLOT);
`default_nettype wire

// ---- verif/tx_clock_sync_pins_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tx_clock_sync_pins_tb;
   logic REF_CLK = 1'b0, TX_LINE_CLK = 1'b0, RST_B = 1'b0, ELASTIC_EN = 1'b0, COMPAT_MODE = 1'b0;
   logic TX_CLK_FROM_RX = 1'b0, IBO_EN = 1'b0, T1_MODE = 1'b1, SYNC_IS_OUT = 1'b1, SYNC_MF = 1'b0;
   logic SYNC_DBL_WIDE = 1'b0, bsync = 1'b0, cmp = 1'b0, armed = 1'b0, prev = 1'b0, wide = 1'b0;
   logic [2:0] BP_RATE = 3'h0, nfr = 3'h1, k = 3'h0;
   logic [1:0] STATUS_SEL = 2'h0;
   logic [6:0] ANALOG_LOSS = 7'h00, FRAMER_LOSS = 7'h00, RX_SIG_FREEZE = 7'h00;
   logic [10:0] last_bit = 11'h000;
   logic [31:0] rnd = 32'h00009A1B;
   logic [15:0] gcnt = 16'h0000, last = 16'h0000, acc = 16'h0000, tol = 16'h0002;
   logic [16:0] q[$];
   logic [16:0] e = 17'h00000;
   int fail_count = 0, num_checks = 0, cyc = 0, hi = 0;
   wire logic TX_SYNC_O, TX_SYNC_OE_B, pclk, psync, gclk, pin;
   wire logic [6:0] STATUS_O, STATUS_OE_B;
   wire logic [2:0] IBO_SLOT;
   always #5 REF_CLK = ~REF_CLK;
   initial
   begin
      #1.7;
      forever #3 TX_LINE_CLK = ~TX_LINE_CLK;
   end
   assign gclk = (ELASTIC_EN | TX_CLK_FROM_RX) ? pclk : TX_LINE_CLK;
   assign pin = !TX_SYNC_OE_B ? TX_SYNC_O : (ELASTIC_EN ? psync : bsync);
   bp_partner i_bp (.line_clk(TX_LINE_CLK), .en(ELASTIC_EN | TX_CLK_FROM_RX), .sync_en(!SYNC_IS_OUT),
      .last_bit(last_bit), .bp_clk(pclk), .sync(psync));
   tx_clock_sync_pins i_dut (.REF_CLK, .RST_B, .TX_LINE_CLK, .RX_REC_CLK(TX_CLK_FROM_RX & pclk),
      .BP_CLK_OWN(!cmp & ELASTIC_EN & pclk), .BP_CLK_ONE(cmp & ELASTIC_EN & pclk), .TX_SYNC_I(pin), .ELASTIC_EN,
      .COMPAT_MODE, .TX_CLK_FROM_RX, .IBO_EN, .BP_RATE, .T1_MODE, .SYNC_IS_OUT, .SYNC_MF, .SYNC_DBL_WIDE,
      .STATUS_SEL, .ANALOG_LOSS, .FRAMER_LOSS, .RX_SIG_FREEZE, .TX_SYNC_O, .TX_SYNC_OE_B, .STATUS_O,
      .STATUS_OE_B, .IBO_SLOT);
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Crossing into the system clock jitters each edge, hence the tolerance
   task automatic check(input logic [15:0] exp, input logic [15:0] seen);
      num_checks++;
      if (seen + tol < exp || seen > exp + tol)
      begin
         fail_count++;
         $display("wrong value sync interval expected %0d seen %0d", exp, seen);
      end
   endtask
   task automatic check_wide(input logic exp, input logic seen);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value double width expected %0d seen %0d", exp, seen);
      end
   endtask
   task automatic run(input logic [4:0] cfg, input logic [2:0] rate, input logic interleaved_bus_mode, input logic [15:0] exp,
                      input logic [2:0] n);
      @(negedge REF_CLK);
      {ELASTIC_EN, cmp, TX_CLK_FROM_RX, T1_MODE, SYNC_MF, BP_RATE, IBO_EN} <= {cfg, rate, interleaved_bus_mode};
      SYNC_DBL_WIDE <= cfg[1] & !cfg[0];
      last_bit <= exp[10:0] - 11'h001;
      repeat (20) @(posedge REF_CLK);
      nfr = n;
      tol = 16'h0002;
      armed = 1'b0;
      // The window spans n intervals; only recovered-clock T1 frame pulses are expected to read wide, line-mode ones are too short
      q.push_back({cfg[2] & !cfg[4] & cfg[1] & !cfg[0], exp * {13'h0000, n}});
      while (q.size() != 0) @(posedge REF_CLK);
   endtask
   task automatic realign(input logic e, input logic [15:0] exp);
      @(negedge REF_CLK);
      {ELASTIC_EN, TX_CLK_FROM_RX, T1_MODE, SYNC_MF, BP_RATE, IBO_EN} <= {e, 1'b0, !e, 1'b0, 3'h1, 1'b0};
      last_bit <= 11'h0FF;
      SYNC_IS_OUT <= 1'b0;
      repeat (700) @(negedge REF_CLK);
      if (e)
         @(posedge psync);
      bsync = !e;
      last = gcnt;
      acc = 16'h0000;
      k = 3'h0;
      nfr = 3'h1;
      tol = 16'h0003;
      armed = 1'b1;
      wide = 1'b0;
      q.push_back({1'b0, exp});
      repeat (2) @(negedge REF_CLK);
      bsync = 1'b0;
      repeat (18) @(negedge REF_CLK);
      SYNC_IS_OUT = 1'b1;
      while (q.size() != 0) @(posedge REF_CLK);
   endtask
   always @(posedge gclk)
   begin
      gcnt <= gcnt + 16'h0001;
   end
   always @(negedge REF_CLK)
   begin
      rnd <= xs(rnd);
      {ANALOG_LOSS, FRAMER_LOSS, RX_SIG_FREEZE, STATUS_SEL} <= rnd[22:0];
      COMPAT_MODE <= ELASTIC_EN ? cmp : rnd[23];
   end
   always @(negedge REF_CLK)
   begin
      if (TX_SYNC_O === 1'b1 && !prev && TX_SYNC_OE_B === 1'b0)
      begin
         if (!armed)
         begin
            armed = 1'b1;
            wide = 1'b0;
            acc = 16'h0000;
            k = 3'h0;
         end
         else
         begin
            acc = acc + (gcnt - last);
            k++;
            if (k == nfr && q.size() != 0)
            begin
               e = q.pop_front();
               check(e[15:0], acc);
               check_wide(e[16], wide);
               acc = 16'h0000;
               k = 3'h0;
            end
         end
         last = gcnt;
      end
      // Two recovered or backplane clock bits hold the pin for at least four reference cycles, one bit at most three
      if (TX_SYNC_O === 1'b1)
      begin
         hi++;
         if (hi == 4)
            wide = 1'b1;
      end
      else
         hi = 0;
      prev = (TX_SYNC_O === 1'b1);
   end
   always @(negedge REF_CLK)
   begin
      cyc++;
      if (cyc == 70000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (16) @(negedge REF_CLK);
      RST_B = 1'b1;
      realign(1'b0, 16'h00CA);
      run(5'h02, 3'h0, 1'h0, 16'h00C1, 3'h4);
      run(5'h00, 3'h0, 1'h0, 16'h0100, 3'h4);
      run(5'h03, 3'h0, 1'h0, 16'h1218, 3'h1);
      run(5'h01, 3'h0, 1'h0, 16'h1000, 3'h1);
      run(5'h06, 3'h0, 1'h0, 16'h00C1, 3'h6);
      realign(1'b1, 16'h0104);
      run(5'h12, 3'h0, 1'h0, 16'h00C1, 3'h4);
      run(5'h18, 3'h1, 1'h0, 16'h0100, 3'h4);
      run(5'h10, 3'h2, 1'h1, 16'h0200, 3'h4);
      run(5'h10, 3'h3, 1'h1, 16'h0400, 3'h2);
      run(5'h10, 3'h4, 1'h1, 16'h0800, 3'h2);
      end_of_test();
   end
endmodule
`default_nettype wire
